// *** rri_top.sv ***
// Special-function register file with reset-category initialisation,
// reached over APB; interrupt status and mask for reset and wake-up events.
// Assumes a single clock, causes reported as one-cycle pulses.
//
// Function
// R01: Interrupt wake with enable loads vector
// R02: Supply dip reset clears power bit 0
// R03: Other resets keep power bit 0
// R04: Analog-selected port pins read zero
// R05: Wake-up leaves interrupt flags set
// R06: Unimplemented bits always read zero
// R07: Unchanged bits keep pre-reset value
// R08: Condition bits follow the actual cause
// R09: Deep supply fall applies power-on values
// R10: Each reset category loads its table values
// R11: Power-on clears power bit 1 only
// R12: Every reset clears global interrupt enable
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
`include "rri_map.svh"
module rri_top
	import rri_pkg::*;
#(
	parameter int APB_AW = 12
)(
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Reset cause report
	input  wire logic              cause_valid,
	input  rri_cause_e             cause,
	input  wire logic              supply_low,
	input  wire logic              osc_stable,
	input  wire logic [7:0]        wake_core_interrupt_control_flags,
	input  wire logic [7:0]        wake_pir_flags,
	// Status out
	output logic                   global_interrupt_enable,
	output logic                   irq
);

	// ============================================================
	// Tables
	localparam int         NREG = `RRI_NREG;
	localparam logic [7:0] OFS  [NREG] = `RRI_OFS;
	localparam logic [7:0] IMPL [NREG] = `RRI_IMPL;
	localparam logic [7:0] PORV [NREG] = `RRI_PORV;
	localparam logic [7:0] PORD [NREG] = `RRI_PORD;
	localparam logic [7:0] RSTV [NREG] = `RRI_RSTV;
	localparam logic [7:0] RSTD [NREG] = `RRI_RSTD;

	function automatic logic [7:0] merge(input logic [7:0] v, input logic [7:0] d,
		input logic [7:0] q);
		merge = (v & d) | (q & ~d);
	endfunction

	// ============================================================
	// Cause decode
	rri_init_s init;

	rri_cause_decode u_dec (
		.cause_valid (cause_valid),
		.cause       (cause),
		.supply_low  (supply_low),
		.init        (init)
	);

	// ============================================================
	// APB decode
	wire logic            setup;
	wire logic            access;
	wire logic [7:0]      idx;
	wire logic            aligned;
	logic      [NREG-1:0] hit;
	wire logic            hit_is;
	wire logic            hit_im;
	wire logic            any_hit;
	wire logic            wr_en;

	assign setup   = psel && !penable;
	assign access  = psel && penable;
	assign idx     = paddr[9:2];
	assign aligned = (paddr[APB_AW-1:10] == '0) && (paddr[1:0] == 2'b00);
	assign hit_is  = aligned && (idx == `RRI_OFS_ISTAT);
	assign hit_im  = aligned && (idx == `RRI_OFS_IMASK);
	assign any_hit = (|hit) || hit_is || hit_im;
	assign wr_en   = access && pwrite && any_hit;
	assign pready  = 1'b1;
	assign pslverr = access && !any_hit;

	// ============================================================
	// Register storage and next values
	logic [7:0] regs_q  [NREG];
	logic [7:0] regs_d  [NREG];
	logic [7:0] tbl_d   [NREG];
	logic [7:0] rd_term [NREG];

	wire logic [7:0] pcl_q;
	wire logic [7:0] status_q;
	wire logic [7:0] power_control_status_q;
	wire logic [7:0] core_interrupt_control_q;
	wire logic [7:0] analog_select_q;
	wire logic [7:0] port_a_data_view;
	wire logic [7:0] port_c_data_view;
	wire logic       gie_pre;
	wire logic [7:0] pcl_step;

	assign pcl_q    = regs_q[`RRI_IX_PCL];
	assign status_q = regs_q[`RRI_IX_STATUS];
	assign power_control_status_q   = regs_q[`RRI_IX_POWER_CONTROL_STATUS];
	assign core_interrupt_control_q = regs_q[`RRI_IX_CORE_INTERRUPT_CONTROL];
	assign analog_select_q  = regs_q[`RRI_IX_ANALOG_SELECT];
	assign gie_pre  = core_interrupt_control_q[`RRI_BIT_GIE];
	assign pcl_step = pcl_q + 8'h01;
	assign global_interrupt_enable = gie_pre;

	// R04: analog pins masked on read
	assign port_a_data_view = regs_q[`RRI_IX_PORT_A_DATA] & {2'b00, ~analog_select_q[5:0]};
	assign port_c_data_view = regs_q[`RRI_IX_PORT_C_DATA] & {6'h3f, ~analog_select_q[7:6]};

	for (genvar i = 0; i < NREG; i++) begin : g_reg
		wire logic wr_hit;

		assign hit[i]  = aligned && (idx == OFS[i]);
		assign wr_hit  = wr_en && hit[i] && (i != `RRI_IX_CONVERTER_RESULT_HIGH);
		// R10: table load per category
		// R07: unchanged bits kept
		assign tbl_d[i] = !init.valid ? (wr_hit ? pwdata[7:0] : regs_q[i]) :
			init.wake ? regs_q[i] :
			init.por ? merge(PORV[i], PORD[i], regs_q[i]) :
			merge(RSTV[i], RSTD[i], regs_q[i]);
		assign rd_term[i] = !hit[i] ? 8'h00 :
			(i == `RRI_IX_PORT_A_DATA) ? port_a_data_view :
			(i == `RRI_IX_PORT_C_DATA) ? port_c_data_view : regs_q[i];

		// R06: unimplemented bits held zero
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				regs_q[i] <= PORV[i] & IMPL[i];
			end else begin
				regs_q[i] <= regs_d[i] & IMPL[i];
			end
		end
	end

	// ============================================================
	// Cause-specific overrides
	always_comb begin
		regs_d = tbl_d;
		if (init.valid) begin
			// R08: time-out and power-down bits
			if (init.to_ld) begin
				regs_d[`RRI_IX_STATUS][`RRI_BIT_TO] = init.to_v;
			end
			if (init.pd_ld) begin
				regs_d[`RRI_IX_STATUS][`RRI_BIT_PD] = init.pd_v;
			end
			// R11: power bit 1 on power-on
			if (init.por) begin
				regs_d[`RRI_IX_POWER_CONTROL_STATUS][`RRI_BIT_PORF] = 1'b0;
			end
			// R02: supply dip flag
			// R03: bit 0 kept otherwise
			if (init.bor) begin
				regs_d[`RRI_IX_POWER_CONTROL_STATUS][`RRI_BIT_BORF] = 1'b0;
			end
			if (init.wake) begin
				// R05: wake cause flags set
				regs_d[`RRI_IX_CORE_INTERRUPT_CONTROL] = core_interrupt_control_q | wake_core_interrupt_control_flags;
				regs_d[`RRI_IX_PERIPHERAL_INTERRUPT_FLAGS]   = regs_q[`RRI_IX_PERIPHERAL_INTERRUPT_FLAGS] | wake_pir_flags;
				// R01: vector or step
				regs_d[`RRI_IX_PCL]    = (init.int_wake && gie_pre) ? `RRI_VECTOR : pcl_step;
			end else begin
				// R12: reset drops global enable
				regs_d[`RRI_IX_CORE_INTERRUPT_CONTROL][`RRI_BIT_GIE] = 1'b0;
				// R08: oscillator status
				regs_d[`RRI_IX_OSCILLATOR_CONTROL][`RRI_BIT_OSTS] = osc_stable;
			end
		end
	end

	// ============================================================
	// Interrupt status and mask
	logic      [`RRI_IRQ_W-1:0] istat_q;
	logic      [`RRI_IRQ_W-1:0] imask_q;
	wire logic [`RRI_IRQ_W-1:0] ev_set;
	wire logic [`RRI_IRQ_W-1:0] ev_clr;
	wire logic [`RRI_IRQ_W-1:0] istat_d;
	wire logic                  other_rst;

	assign other_rst = init.valid && !init.wake && !init.por && !init.bor;
	assign ev_set    = {other_rst, init.wake, init.bor, init.por};
	assign ev_clr    = (wr_en && hit_is) ? pwdata[`RRI_IRQ_W-1:0] : '0;
	assign istat_d   = (istat_q & ~ev_clr) | ev_set;
	assign irq       = |(istat_q & imask_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat_q <= '0;
			imask_q <= '0;
		end else begin
			istat_q <= istat_d;
			imask_q <= (wr_en && hit_im) ? pwdata[`RRI_IRQ_W-1:0] : imask_q;
		end
	end

	// ============================================================
	// Read data
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = 8'h00;
		for (int i = 0; i < NREG; i++) begin
			rd_mux = rd_mux | rd_term[i];
		end
		if (hit_is) begin
			rd_mux = {4'h0, istat_q};
		end
		if (hit_im) begin
			rd_mux = {4'h0, imask_q};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata <= {24'h00_0000, rd_mux};
		end
	end

	// ============================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_port_a_data_read;
		setup && !pwrite && hit[`RRI_IX_PORT_A_DATA] ##1 access;
	endsequence

	sequence s_port_c_data_read;
		setup && !pwrite && hit[`RRI_IX_PORT_C_DATA] ##1 access;
	endsequence

	a_wake_vector_load: assert property ( // R01
		init.int_wake && gie_pre |=> pcl_q == `RRI_VECTOR)
		else $error("interrupt wake did not load vector");
	a_wake_pc_step: assert property ( // R01
		init.wake && !(init.int_wake && gie_pre) |=> pcl_q == $past(pcl_step))
		else $error("wake did not advance counter");
	a_dip_flag_clear: assert property ( // R02
		init.bor |=> !power_control_status_q[`RRI_BIT_BORF])
		else $error("supply dip flag not cleared");
	a_dip_flag_keep: assert property ( // R03
		init.valid && !init.bor |=> power_control_status_q[`RRI_BIT_BORF] == $past(power_control_status_q[`RRI_BIT_BORF]))
		else $error("supply dip flag changed");
	a_analog_read_zero: assert property ( // R04
		s_port_a_data_read |-> (prdata[5:0] & $past(analog_select_q[5:0])) == 6'h00)
		else $error("analog pin read nonzero");
	a_wake_flags_set: assert property ( // R05
		init.wake |=> (core_interrupt_control_q & $past(wake_core_interrupt_control_flags)) == $past(wake_core_interrupt_control_flags))
		else $error("wake flags not set");
	a_unimpl_zero: assert property ( // R06
		power_control_status_q[7:4] == 4'h0 && regs_q[`RRI_IX_PORT_A_DATA][7:6] == 2'b00)
		else $error("unimplemented bit set");
	a_wake_keeps_regs: assert property ( // R07
		init.wake |=> regs_q[`RRI_IX_TIMER0_COUNT] == $past(regs_q[`RRI_IX_TIMER0_COUNT]) &&
			regs_q[`RRI_IX_PORT_A_DIRECTION] == $past(regs_q[`RRI_IX_PORT_A_DIRECTION]))
		else $error("wake changed kept register");
	a_wdt_timeout_bit: assert property ( // R08
		cause_valid && cause == RRI_WDT_RST && !supply_low
		|=> !status_q[`RRI_BIT_TO] ##1
			(!status_q[`RRI_BIT_TO] || $past(wr_en) || $past(cause_valid)))
		else $error("time-out bit not cleared");
	a_dip_forces_por: assert property ( // R09
		cause_valid && supply_low && cause == RRI_MASTER_CLEAR_PIN_RUN
		|=> status_q[`RRI_BIT_TO] && status_q[`RRI_BIT_PD] && !power_control_status_q[`RRI_BIT_PORF])
		else $error("deep dip did not apply power-on");
	a_table_values: assert property ( // R10
		init.valid && !init.wake |=> regs_q[`RRI_IX_PORT_A_DIRECTION] == 8'h3f &&
			regs_q[`RRI_IX_TIMER2_COUNT] == 8'h00 && pcl_q == 8'h00)
		else $error("reset table not loaded");
	a_por_bit_keep: assert property ( // R11
		init.valid && !init.por
		|=> power_control_status_q[`RRI_BIT_PORF] == $past(power_control_status_q[`RRI_BIT_PORF]))
		else $error("power-on bit changed");
	a_reset_gie_low: assert property ( // R12
		init.valid && !init.wake |=> !global_interrupt_enable)
		else $error("global enable survived reset");
	a_analog_port_c_data_zero: assert property ( // R04
		s_port_c_data_read |-> (prdata[1:0] & $past(analog_select_q[7:6])) == 2'b00)
		else $error("analog port c pin read nonzero");
	a_por_flag_clear: assert property ( // R11
		init.por |=> !power_control_status_q[`RRI_BIT_PORF])
		else $error("power-on bit not cleared");
	a_osc_status_load: assert property ( // R08
		init.valid && !init.wake
		|=> regs_q[`RRI_IX_OSCILLATOR_CONTROL][`RRI_BIT_OSTS] == $past(osc_stable))
		else $error("oscillator status not loaded");

endmodule

// *** rri_map.svh ***
// Register map, reset tables and field positions of the reset initialiser.
// Assumes inclusion by bare name; definitions only.
`ifndef RRI_MAP_SVH
`define RRI_MAP_SVH

// ============================================================
// Register table, one entry per register index
`define RRI_NREG 33
`define RRI_OFS '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h0a, 8'h0b, 8'h0c, \
	8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, \
	8'h19, 8'h1a, 8'h1e, 8'h1f, 8'h81, 8'h85, 8'h87, 8'h8c, 8'h8e, 8'h8f, 8'h91, 8'ha2}
`define RRI_IMPL '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h3f, 8'h1f, 8'hff, 8'hff, \
	8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f, \
	8'hff, 8'h03, 8'hff, 8'hdf, 8'hff, 8'h3f, 8'h3f, 8'hff, 8'h0f, 8'h7f, 8'hff, 8'hff}
`define RRI_PORV '{8'h00, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, \
	8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, \
	8'h00, 8'h02, 8'h00, 8'h00, 8'hff, 8'h3f, 8'h3f, 8'h00, 8'h04, 8'h60, 8'hff, 8'h00}
`define RRI_PORD '{8'h00, 8'h00, 8'hff, 8'hf8, 8'h00, 8'h17, 8'h0f, 8'h1f, 8'hff, 8'hff, \
	8'h00, 8'h00, 8'hff, 8'hff, 8'h7f, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'h1f, \
	8'hff, 8'h03, 8'h00, 8'hdf, 8'hff, 8'h3f, 8'h3f, 8'hff, 8'h0e, 8'h77, 8'hff, 8'h00}
`define RRI_RSTV '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, \
	8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, \
	8'h00, 8'h02, 8'h00, 8'h00, 8'hff, 8'h3f, 8'h3f, 8'h00, 8'h00, 8'h60, 8'hff, 8'h00}
`define RRI_RSTD '{8'h00, 8'h00, 8'hff, 8'he0, 8'h00, 8'h17, 8'h0f, 8'h1f, 8'hff, 8'hff, \
	8'h00, 8'h00, 8'h00, 8'hff, 8'h7f, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'h1f, \
	8'hff, 8'h03, 8'h00, 8'hdf, 8'hff, 8'h3f, 8'h3f, 8'hff, 8'h08, 8'h77, 8'hff, 8'h00}

// ============================================================
// Indices of registers with special handling
`define RRI_IX_PCL    2
`define RRI_IX_STATUS 3
`define RRI_IX_TIMER0_COUNT   1
`define RRI_IX_PORT_A_DATA  5
`define RRI_IX_PORT_C_DATA  6
`define RRI_IX_CORE_INTERRUPT_CONTROL 8
`define RRI_IX_PERIPHERAL_INTERRUPT_FLAGS   9
`define RRI_IX_TIMER2_COUNT   13
`define RRI_IX_CONVERTER_RESULT_HIGH 23
`define RRI_IX_PORT_A_DIRECTION  26
`define RRI_IX_POWER_CONTROL_STATUS   29
`define RRI_IX_OSCILLATOR_CONTROL 30
`define RRI_IX_ANALOG_SELECT  31

// ============================================================
// Field positions and constants
`define RRI_BIT_TO    4
`define RRI_BIT_PD    3
`define RRI_BIT_GIE   7
`define RRI_BIT_PORF  1
`define RRI_BIT_BORF  0
`define RRI_BIT_OSTS  3
`define RRI_VECTOR    8'h04
`define RRI_OFS_ISTAT 8'ha0
`define RRI_OFS_IMASK 8'ha1
`define RRI_IRQ_W     4

`endif

// *** rri_pkg.sv ***
// Types shared by the reset initialiser modules.
// Assumes nothing beyond a SystemVerilog compiler.
package rri_pkg;

	// ============================================================
	// Reset and wake-up categories
	typedef enum logic [2:0] {
		RRI_POR        = 3'b000,
		RRI_MASTER_CLEAR_PIN_RUN   = 3'b001,
		RRI_MASTER_CLEAR_PIN_SLEEP = 3'b011,
		RRI_WDT_RST    = 3'b010,
		RRI_BOR        = 3'b110,
		RRI_WDT_WAKE   = 3'b111,
		RRI_INT_WAKE   = 3'b101
	} rri_cause_e;

	// ============================================================
	// Decoded initialisation request
	typedef struct packed {
		logic valid;
		logic por;
		logic bor;
		logic wake;
		logic int_wake;
		logic to_ld;
		logic to_v;
		logic pd_ld;
		logic pd_v;
	} rri_init_s;

endpackage

// *** rri_cause_decode.sv ***
// Decoder from reset cause to the initialisation request.
// Assumes cause inputs are synchronous and one-cycle valid.
`timescale 1ns/1ns
module rri_cause_decode
	import rri_pkg::*;
(
	// Cause in
	input  wire logic       cause_valid,
	input  rri_cause_e      cause,
	input  wire logic       supply_low,
	// Request out
	output rri_init_s       init
);

	// ============================================================
	// Time-out and power-down bits per cause
	function automatic logic [3:0] topd(input rri_cause_e c);
		case (c)
			RRI_POR:        topd = 4'hf;
			RRI_BOR:        topd = 4'hf;
			RRI_MASTER_CLEAR_PIN_SLEEP: topd = 4'he;
			RRI_INT_WAKE:   topd = 4'he;
			RRI_WDT_RST:    topd = 4'h8;
			RRI_WDT_WAKE:   topd = 4'ha;
			default:        topd = 4'h0;
		endcase
	endfunction

	// ============================================================
	// Effective cause
	wire logic       drop_cat;
	rri_cause_e      eff;
	wire logic [3:0] tp;

	assign drop_cat = (cause == RRI_MASTER_CLEAR_PIN_RUN) || (cause == RRI_MASTER_CLEAR_PIN_SLEEP) ||
		(cause == RRI_WDT_RST) || (cause == RRI_BOR);
	// R09: deep dip forces power-on
	assign eff = (supply_low && drop_cat) ? RRI_POR : cause;
	// R08: cause picks status bits
	assign tp = topd(eff);

	assign init.valid    = cause_valid;
	assign init.por      = cause_valid && (eff == RRI_POR);
	assign init.bor      = cause_valid && (eff == RRI_BOR);
	assign init.wake     = cause_valid && ((eff == RRI_WDT_WAKE) || (eff == RRI_INT_WAKE));
	assign init.int_wake = cause_valid && (eff == RRI_INT_WAKE);
	assign init.to_ld    = tp[3];
	assign init.to_v     = tp[2];
	assign init.pd_ld    = tp[1];
	assign init.pd_v     = tp[0];

endmodule

// *** rri_top_tb.sv ***
// Self-checking bench for the reset initialiser register file.
// Assumes rri_top with zero-wait APB and one-cycle cause pulses.
`timescale 1ns/1ns
`include "rri_map.svh"
module rri_top_tb
	import rri_pkg::*;
;
	// ============================================================
	// Signals
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cause_valid;
	rri_cause_e  cause;
	logic        supply_low;
	logic        osc_stable;
	logic [7:0]  wake_core_interrupt_control_flags;
	logic [7:0]  wake_pir_flags;
	logic        global_interrupt_enable;
	logic        irq;
	int          error_cnt;
	int          checks_done;
	int          cyc_cnt;
	logic [7:0]  last_rd;
	logic        last_err;
	rri_cause_e  seq_c [7] = '{RRI_POR, RRI_WDT_RST, RRI_MASTER_CLEAR_PIN_SLEEP, RRI_WDT_WAKE,
		RRI_MASTER_CLEAR_PIN_RUN, RRI_INT_WAKE, RRI_BOR};
	logic [7:0]  seq_s [7] = '{8'h18, 8'h08, 8'h10, 8'h00, 8'h00, 8'h10, 8'h18};

	// ============================================================
	// Design
	rri_top #(.APB_AW(12)) u_dut (
		.pclk                    (pclk),
		.presetn                 (presetn),
		.psel                    (psel),
		.penable                 (penable),
		.pwrite                  (pwrite),
		.paddr                   (paddr),
		.pwdata                  (pwdata),
		.prdata                  (prdata),
		.pready                  (pready),
		.pslverr                 (pslverr),
		.cause_valid             (cause_valid),
		.cause                   (cause),
		.supply_low              (supply_low),
		.osc_stable              (osc_stable),
		.wake_core_interrupt_control_flags       (wake_core_interrupt_control_flags),
		.wake_pir_flags          (wake_pir_flags),
		.global_interrupt_enable (global_interrupt_enable),
		.irq                     (irq)
	);

	// ============================================================
	// Clock and timeout
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 3000) begin
			error_cnt++;
			complete_run();
		end
	end

	// ============================================================
	// Tasks
	task complete_run();
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task apb(input logic wr, input logic [7:0] ix, input logic [7:0] wd);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {2'b00, ix, 2'b00};
		pwdata  <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		last_rd  = prdata[7:0];
		last_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] ix, input logic [7:0] d);
		apb(1'b1, ix, d);
	endtask

	task rdc(input logic [7:0] ix, input logic [7:0] msk, input logic [7:0] exp);
		apb(1'b0, ix, 8'h00);
		chk(last_rd & msk, exp);
	endtask

	task fire(input rri_cause_e c, input logic low);
		@(posedge pclk);
		cause_valid <= 1'b1;
		cause       <= c;
		supply_low  <= low;
		@(posedge pclk);
		cause_valid <= 1'b0;
		supply_low  <= 1'b0;
		@(negedge pclk);
	endtask

	// ============================================================
	// Main sequence
	initial begin
		{psel, penable, pwrite, cause_valid, supply_low, osc_stable} = '0;
		paddr = '0;
		pwdata = '0;
		cause = RRI_POR;
		wake_core_interrupt_control_flags = '0;
		wake_pir_flags = '0;
		error_cnt = 0;
		checks_done = 0;
		cyc_cnt = 0;
		presetn = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rdc(8'h81, 8'hff, 8'hff);
		rdc(8'h85, 8'hff, 8'h3f);
		rdc(8'h03, 8'hff, 8'h18);
		rdc(8'h8e, 8'hff, 8'h04);
		rdc(8'h1a, 8'hff, 8'h02);
		rdc(8'h0b, 8'hff, 8'h00);
		wr(8'h0a, 8'hff);
		rdc(8'h0a, 8'hff, 8'h1f);
		wr(8'h18, 8'hff);
		rdc(8'h18, 8'hff, 8'h1f);
		wr(8'h05, 8'h3f);
		rdc(8'h05, 8'hff, 8'h00);
		wr(8'h91, 8'h00);
		rdc(8'h05, 8'hff, 8'h3f);
		fire(RRI_MASTER_CLEAR_PIN_RUN, 1'b0);
		rdc(8'h05, 8'hff, 8'h00);
		wr(8'h91, 8'h00);
		rdc(8'h05, 8'hff, 8'h28);
		wr(8'h01, 8'h5a);
		wr(8'h11, 8'h33);
		fire(RRI_MASTER_CLEAR_PIN_RUN, 1'b0);
		rdc(8'h01, 8'hff, 8'h5a);
		rdc(8'h11, 8'hff, 8'h00);
		wr(8'h8e, 8'h03);
		fire(RRI_MASTER_CLEAR_PIN_RUN, 1'b0);
		rdc(8'h8e, 8'h03, 8'h03);
		fire(RRI_BOR, 1'b0);
		rdc(8'h8e, 8'h03, 8'h02);
		wr(8'h8e, 8'h03);
		fire(RRI_WDT_RST, 1'b1);
		rdc(8'h8e, 8'h03, 8'h01);
		wr(8'h8e, 8'h03);
		fire(RRI_POR, 1'b0);
		rdc(8'h8e, 8'h03, 8'h01);
		wr(8'h0b, 8'h80);
		@(negedge pclk);
		chk({7'h0, global_interrupt_enable}, 8'h01);
		fire(RRI_WDT_RST, 1'b0);
		chk({7'h0, global_interrupt_enable}, 8'h00);
		rdc(8'h0b, 8'hff, 8'h00);
		wr(8'h0b, 8'h80);
		wr(8'h02, 8'h10);
		wake_core_interrupt_control_flags <= 8'h02;
		fire(RRI_INT_WAKE, 1'b0);
		rdc(8'h02, 8'hff, 8'h04);
		rdc(8'h0b, 8'hff, 8'h82);
		wr(8'h0b, 8'h00);
		wr(8'h02, 8'h10);
		fire(RRI_INT_WAKE, 1'b0);
		rdc(8'h02, 8'hff, 8'h11);
		wake_core_interrupt_control_flags <= 8'h00;
		wake_pir_flags <= 8'h01;
		fire(RRI_WDT_WAKE, 1'b0);
		rdc(8'h0c, 8'hff, 8'h01);
		rdc(8'h02, 8'hff, 8'h12);
		wake_pir_flags <= 8'h00;
		for (int i = 0; i < 7; i++) begin
			fire(seq_c[i], 1'b0);
			rdc(8'h03, 8'h18, seq_s[i]);
		end
		for (int i = 0; i < 2; i++) begin
			osc_stable <= ~osc_stable;
			fire(RRI_MASTER_CLEAR_PIN_RUN, 1'b0);
			rdc(8'h8f, 8'h08, {4'h0, osc_stable, 3'h0});
		end
		wr(8'ha0, 8'h0f);
		wr(8'ha1, 8'h02);
		fire(RRI_BOR, 1'b0);
		chk({7'h0, irq}, 8'h01);
		rdc(8'ha0, 8'h0f, 8'h02);
		wr(8'ha0, 8'h0f);
		@(negedge pclk);
		chk({7'h0, irq}, 8'h00);
		wr(8'ha1, 8'h00);
		fire(RRI_BOR, 1'b0);
		chk({7'h0, irq}, 8'h00);
		rdc(8'ha0, 8'h0f, 8'h02);
		apb(1'b0, 8'h06, 8'h00);
		chk({7'h0, last_err}, 8'h01);
		chk(last_rd, 8'h00);
		wr(8'h1e, 8'h55);
		rdc(8'h1e, 8'hff, 8'h00);
		wr(8'h07, 8'h3f);
		rdc(8'h07, 8'hff, 8'h3c);
		wr(8'h91, 8'h00);
		rdc(8'h07, 8'hff, 8'h3f);
		wr(8'h8e, 8'h03);
		fire(RRI_MASTER_CLEAR_PIN_RUN, 1'b1);
		rdc(8'h8e, 8'h03, 8'h01);
		rdc(8'h03, 8'h18, 8'h18);
		rdc(8'h07, 8'h0f, 8'h00);
		complete_run();
	end
endmodule
